// ==== rtl/sc_char_pkg.sv ====
/*
 * shared constants for the smart card character controller: register
 * indices, field positions, reset values and timing counts.
 * assumes a 32-bit AHB-Lite register bus and a 100 MHz hclk.
 */
package sc_char_pkg;
    // register indices; byte address is four times the index
    localparam logic [15:0] PARITY_CTRL_IDX = 16'hFE11;
    localparam logic [15:0] CONV_CTRL_IDX = 16'hFE12;
    localparam logic [15:0] ETU_RATE_IDX = 16'hFE13;
    localparam logic [15:0] LINK_CTRL_IDX = 16'hFE20;
    localparam logic [15:0] LINK_STATUS_IDX = 16'hFE21;

    // parity control fields
    localparam int PAR_DISABLE_BIT = 6;
    localparam int BRK_GEN_DISABLE_BIT = 5;
    localparam logic [7:0] PARITY_CTRL_RESET = 8'h00;

    // character convention control fields
    localparam int DETECT_BIT = 6;
    localparam int CONV_BIT = 5;
    localparam int BRK_LEN_LSB = 3;
    localparam logic [7:0] CONV_CTRL_RESET = 8'h2C;

    // rate factor fields, F code high nibble, D code low nibble
    localparam int F_CODE_LSB = 4;
    localparam logic [7:0] ETU_RATE_RESET = 8'h11;

    // link control: bit 0 selects T=1 (0 means T=0)
    localparam int PROTO_T1_BIT = 0;
    localparam logic [7:0] LINK_CTRL_RESET = 8'h00;

    // link status fields
    localparam int ST_PAR_ERR_BIT = 0;
    localparam int ST_BRK_SEEN_BIT = 1;
    localparam int ST_BUSY_BIT = 2;

    // hclk cycles per intermediate clock tick
    localparam logic [3:0] ICLK_RATIO = 4'hD;

    // TS patterns as first seen on the line, least significant bit first
    localparam logic [7:0] TS_DIRECT_RAW = 8'h3B;
    localparam logic [7:0] TS_INVERSE_RAW = 8'h03;

    // character timing in half ETU steps from the start bit edge
    localparam logic [4:0] RX_END_HALF = 5'h14;      // 10 ETU
    localparam logic [4:0] BRK_START_HALF = 5'h15;   // 10.5 ETU
    localparam logic [4:0] BRK_SAMPLE_HALF = 5'h16;  // 11 ETU
    localparam logic [4:0] PARITY_HALF = 5'h13;      // middle of bit 9

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RX = 3'b010,
        ST_TX = 3'b100
    } state_type;
endpackage

// ==== rtl/etu_half_timer.sv ====
/*
 * ETU timer: maps the F and D codes to an ETU divisor and emits one pulse
 * every half ETU of intermediate clock ticks.
 * assumes tick is a one-cycle enable at the intermediate clock rate.
 */
`timescale 1ns/1ps
module etu_half_timer (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic tick,
    input wire logic restart,
    input wire logic [3:0] f_code,
    input wire logic [3:0] d_code,
    output logic half_step
);
    logic [12:0] two_fi;
    logic [12:0] divisor;
    logic [11:0] half_div;
    logic [12:0] cnt_q;
    logic at_half;
    logic at_end;

    // twice the Fi ratio; unlisted codes take fixed stand-in ratios
    always_comb
    begin
        case (f_code)
            4'h0, 4'h1: two_fi = 13'h02E8;
            4'h2: two_fi = 13'h045C;
            4'h3: two_fi = 13'h05D0;
            4'h4: two_fi = 13'h08B8;
            4'h5: two_fi = 13'h0BA0;
            4'h6, 4'h7: two_fi = 13'h0E88;
            4'h8, 4'h9: two_fi = 13'h0400;
            4'hA: two_fi = 13'h0600;
            4'hB: two_fi = 13'h0800;
            4'hC: two_fi = 13'h0C00;
            default: two_fi = 13'h1000;
        endcase
    end

    // divide by twice Fi over Di
    // up to 4096 in 13 bits
    // rounded to nearest; constant divisors keep the divide cheap
    always_comb
    begin
        case (d_code)
            4'h0, 4'h1: divisor = two_fi;
            4'h2: divisor = (two_fi + 13'h0001) >> 1;
            4'h3: divisor = (two_fi + 13'h0002) >> 2;
            4'h4: divisor = (two_fi + 13'h0004) >> 3;
            4'h5: divisor = (two_fi + 13'h0008) >> 4;
            4'h6, 4'h7: divisor = (two_fi + 13'h0010) >> 5;
            4'h8: divisor = 13'((two_fi + 13'h0006) / 13'h000C);
            4'h9: divisor = 13'((two_fi + 13'h000A) / 13'h0014);
            default: divisor = (two_fi + 13'h0008) >> 4;
        endcase
    end

    assign half_div = divisor[12:1];
    assign at_half = cnt_q == {1'b0, half_div - 12'h001};
    assign at_end = cnt_q == divisor - 13'h0001;

    // tick counter within one ETU
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cnt_q <= 13'h0000;
        else if (restart)
            cnt_q <= 13'h0000;
        else if (tick)
            cnt_q <= at_end ? 13'h0000 : cnt_q + 13'h0001;
    end

    // one pulse at each half and whole ETU
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            half_step <= 1'b0;
        else
            half_step <= tick && !restart && (at_half || at_end);
    end
endmodule // etu_half_timer

// ==== rtl/sc_char_ctrl.sv ====
/*
 * smart card character controller: TS convention detection, receive
 * parity break, simple transmit with break sampling, ETU and card clock.
 * assumes one AHB-Lite master, io_in synchronous to hclk, and a receive
 * FIFO outside that takes rx_data on rx_valid.
 */
// The AHB-Lite slave port was chosen for this implementation.
// Contract
// - while the detect bit is set the next received character is taken as TS and sets the convention if it matches a TS pattern.
// - without a TS detection or a write of the convention bit the block stays in direct convention.
// - TS is parity checked and may raise a break under the same settings as any character.
// - the detect bit clears itself once TS has been received.
// - TS is decoded before the receive FIFO and is still written into it.
// - the convention bit is 1 after a direct TS and 0 after an inverse one, and firmware may write it.
// - a T=0 parity break lasts 1, 1.5 or 2 ETU for codes 00, 01 and 10, code 11 reserved.
// - the card clock is the intermediate clock divided by 2.
// - the ETU is the intermediate clock divided by twice Fi over Di.
// - F over D ratios up to 2048 are supported.
// - the F code maps to Fi and resets to 0001, Fi 372.
// - the D code maps to Di and resets to 0001, Di 1.
// - a receive break starts 10.5 ETU after the start bit edge.
// - a card break after a sent character is sampled 11 ETU after its start bit.
`timescale 1ns/1ps
module sc_char_ctrl (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic io_in,
    output logic io_out,
    output logic io_oe,
    output logic card_clk,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_busy,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_parity_err
);
    sc_char_pkg::state_type state_q;
    logic [7:0] parity_ctrl_q;
    logic [3:0] conv_ctrl_q;
    logic [7:0] etu_rate_q;
    logic [7:0] link_ctrl_q;
    logic par_err_q;
    logic brk_seen_q;
    logic wr_pend_q;
    logic [13:0] wr_idx_q;
    logic [3:0] iclk_cnt_q;
    logic tick_q;
    logic io_prev_q;
    logic [4:0] hpos_q;
    logic [9:0] rx_raw_q;
    logic [9:0] tx_frame_q;
    logic brk_on_q;
    logic half_step;

    // bus decode; hsize is always a whole word here
    wire addr_phase = hsel && htrans[1] && hready;
    wire [13:0] rd_idx = haddr[15:2];
    wire wr_now = wr_pend_q;
    wire [7:0] wbyte = hwdata[7:0];
    wire wr_par = wr_now && wr_idx_q == sc_char_pkg::PARITY_CTRL_IDX[13:0];
    wire wr_conv = wr_now && wr_idx_q == sc_char_pkg::CONV_CTRL_IDX[13:0];
    wire wr_rate = wr_now && wr_idx_q == sc_char_pkg::ETU_RATE_IDX[13:0];
    wire wr_link = wr_now && wr_idx_q == sc_char_pkg::LINK_CTRL_IDX[13:0];
    wire [2:0] hsize_unused = hsize;

    // reserved low bits of the convention register read their reset value
    wire [7:0] conv_rd = {1'b0, conv_ctrl_q, sc_char_pkg::CONV_CTRL_RESET[2:0]};
    wire [7:0] status_rd = {5'h00, state_q != sc_char_pkg::ST_IDLE, brk_seen_q, par_err_q};

    // read mux; unmapped addresses read zero
    wire [7:0] rd_byte =
        (rd_idx == sc_char_pkg::PARITY_CTRL_IDX[13:0]) ? parity_ctrl_q :
        (rd_idx == sc_char_pkg::CONV_CTRL_IDX[13:0]) ? conv_rd :
        (rd_idx == sc_char_pkg::ETU_RATE_IDX[13:0]) ? etu_rate_q :
        (rd_idx == sc_char_pkg::LINK_CTRL_IDX[13:0]) ? link_ctrl_q :
        (rd_idx == sc_char_pkg::LINK_STATUS_IDX[13:0]) ? status_rd : 8'h00;

    // control fields
    wire detect_en = conv_ctrl_q[sc_char_pkg::DETECT_BIT - 3];
    wire conv_direct = conv_ctrl_q[sc_char_pkg::CONV_BIT - 3];
    wire [1:0] brk_len = conv_ctrl_q[1:0];
    wire par_check = !parity_ctrl_q[sc_char_pkg::PAR_DISABLE_BIT];
    wire brk_gen = !parity_ctrl_q[sc_char_pkg::BRK_GEN_DISABLE_BIT];
    wire proto_t0 = !link_ctrl_q[sc_char_pkg::PROTO_T1_BIT];

    // receive decode at the parity sample, line bits in arrival order
    wire [4:0] hpos_next = hpos_q + 5'h01;
    wire in_rx = state_q == sc_char_pkg::ST_RX;
    wire in_tx = state_q == sc_char_pkg::ST_TX;
    wire [7:0] raw_bits = rx_raw_q[9:2];
    wire raw_par = io_in;
    // TS sets the convention from its own pattern
    wire ts_direct = detect_en && raw_bits == sc_char_pkg::TS_DIRECT_RAW;
    wire ts_inverse = detect_en && raw_bits == sc_char_pkg::TS_INVERSE_RAW;
    // convention only changes on a detected TS or a write
    wire use_direct = ts_direct ? 1'b1 : (ts_inverse ? 1'b0 : conv_direct);
    wire [7:0] raw_rev = {<<{raw_bits}};
    wire [7:0] log_data = use_direct ? raw_bits : ~raw_rev;
    wire log_par = use_direct ? raw_par : ~raw_par;
    // TS checked like any other character
    wire par_bad = par_check && (^{log_data, log_par});
    wire parity_point = in_rx && half_step && hpos_next == sc_char_pkg::PARITY_HALF;
    wire want_brk = par_bad && proto_t0 && brk_gen;

    // break end position from the length code; reserved code acts as 2 ETU
    wire [4:0] brk_end =
        (brk_len == 2'b00) ? sc_char_pkg::BRK_START_HALF + 5'h02 :
        (brk_len == 2'b01) ? sc_char_pkg::BRK_START_HALF + 5'h03 :
        sc_char_pkg::BRK_START_HALF + 5'h04;

    // transmit frame in line levels
    wire [7:0] tx_rev = {<<{tx_data}};
    wire tx_par = ^tx_data;
    wire [9:0] tx_line = conv_direct ? {tx_par, tx_data, 1'b0} : {~tx_par, ~tx_rev, 1'b0};
    wire start_edge = state_q == sc_char_pkg::ST_IDLE && io_prev_q && !io_in;
    wire tx_take = state_q == sc_char_pkg::ST_IDLE && tx_valid && !start_edge;
    wire restart = start_edge || tx_take;

    // intermediate clock tick, card clock toggles once per tick
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            iclk_cnt_q <= 4'h0;
            tick_q <= 1'b0;
            card_clk <= 1'b0;
        end
        else
        begin
            tick_q <= iclk_cnt_q == sc_char_pkg::ICLK_RATIO - 4'h1;
            iclk_cnt_q <= tick_q ? 4'h1 : iclk_cnt_q + 4'h1;
            if (tick_q)
                card_clk <= !card_clk;
        end
    end

    // half ETU steps from the selected F and D codes
    etu_half_timer u_etu (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(tick_q),
        .restart(restart),
        .f_code(etu_rate_q[7:sc_char_pkg::F_CODE_LSB]),
        .d_code(etu_rate_q[3:0]),
        .half_step(half_step)
    );

    // bus handshake: zero wait state, always OKAY
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_idx_q <= 14'h0000;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            wr_pend_q <= addr_phase && hwrite;
            wr_idx_q <= addr_phase ? rd_idx : wr_idx_q;
            if (addr_phase && !hwrite)
                hrdata <= {24'h000000, rd_byte};
        end
    end

    // plain control registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            parity_ctrl_q <= sc_char_pkg::PARITY_CTRL_RESET;
            etu_rate_q <= sc_char_pkg::ETU_RATE_RESET;
            link_ctrl_q <= sc_char_pkg::LINK_CTRL_RESET;
        end
        else
        begin
            if (wr_par)
                parity_ctrl_q <= {1'b0, wbyte[6:0]};
            if (wr_rate)
                etu_rate_q <= wbyte;
            if (wr_link)
                link_ctrl_q <= {7'h00, wbyte[0]};
        end
    end

    // convention register; a TS result beats a same-cycle write of the bit
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            conv_ctrl_q <= sc_char_pkg::CONV_CTRL_RESET[6:3];
        else
        begin
            if (wr_conv)
                conv_ctrl_q <= wbyte[6:3];
            // detect bit drops after TS, unless rewritten now
            if (parity_point && detect_en && !wr_conv)
                conv_ctrl_q[sc_char_pkg::DETECT_BIT - 3] <= 1'b0;
            if (parity_point && (ts_direct || ts_inverse))
                conv_ctrl_q[sc_char_pkg::CONV_BIT - 3] <= ts_direct;
        end
    end

    // character sequencer
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q <= sc_char_pkg::ST_IDLE;
            hpos_q <= 5'h00;
            tx_frame_q <= 10'h3FF;
            io_prev_q <= 1'b1;
        end
        else
        begin
            io_prev_q <= io_in;
            case (state_q)
                sc_char_pkg::ST_IDLE:
                begin
                    hpos_q <= 5'h00;
                    if (start_edge)
                        state_q <= sc_char_pkg::ST_RX;
                    else if (tx_take)
                    begin
                        state_q <= sc_char_pkg::ST_TX;
                        tx_frame_q <= tx_line;
                    end
                end
                sc_char_pkg::ST_RX:
                begin
                    if (half_step)
                        hpos_q <= hpos_next;
                    // glitch: start bit not low at its middle
                    if (half_step && hpos_next == 5'h01 && io_in)
                        state_q <= sc_char_pkg::ST_IDLE;
                    else if (half_step && !brk_on_q && hpos_next == sc_char_pkg::RX_END_HALF)
                        state_q <= sc_char_pkg::ST_IDLE;
                    else if (half_step && brk_on_q && hpos_next == brk_end)
                        state_q <= sc_char_pkg::ST_IDLE;
                end
                sc_char_pkg::ST_TX:
                begin
                    if (half_step)
                        hpos_q <= hpos_next;
                    if (half_step && !hpos_next[0] && hpos_next < sc_char_pkg::RX_END_HALF)
                        tx_frame_q <= {1'b1, tx_frame_q[9:1]};
                    // card break looked at once, 11 ETU in
                    if (half_step && hpos_next == sc_char_pkg::BRK_SAMPLE_HALF)
                        state_q <= sc_char_pkg::ST_IDLE;
                end
                default:
                    state_q <= sc_char_pkg::ST_IDLE;
            endcase
        end
    end

    // receive shift, results and break request
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rx_raw_q <= 10'h000;
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
            rx_parity_err <= 1'b0;
            brk_on_q <= 1'b0;
        end
        else
        begin
            rx_valid <= 1'b0;
            if (in_rx && half_step && hpos_next[0])
                rx_raw_q <= {io_in, rx_raw_q[9:1]};
            // decoded TS still goes to the FIFO
            if (parity_point)
            begin
                rx_data <= log_data;
                rx_valid <= 1'b1;
                rx_parity_err <= par_bad;
                brk_on_q <= want_brk;
            end
            if (state_q == sc_char_pkg::ST_IDLE)
                brk_on_q <= 1'b0;
        end
    end

    // sticky status; a new event wins over the clearing write
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            par_err_q <= 1'b0;
            brk_seen_q <= 1'b0;
        end
        else
        begin
            if (parity_point && par_bad)
                par_err_q <= 1'b1;
            else if (wr_now && wr_idx_q == sc_char_pkg::LINK_STATUS_IDX[13:0]
                && wbyte[sc_char_pkg::ST_PAR_ERR_BIT])
                par_err_q <= 1'b0;
            if (in_tx && half_step && hpos_next == sc_char_pkg::BRK_SAMPLE_HALF
                && !io_in && proto_t0)
                brk_seen_q <= 1'b1;
            else if (wr_now && wr_idx_q == sc_char_pkg::LINK_STATUS_IDX[13:0]
                && wbyte[sc_char_pkg::ST_BRK_SEEN_BIT])
                brk_seen_q <= 1'b0;
        end
    end

    // line driver: transmit frame, or the receive break
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            io_out <= 1'b1;
            io_oe <= 1'b0;
            tx_busy <= 1'b0;
        end
        else
        begin
            tx_busy <= (state_q != sc_char_pkg::ST_IDLE) || tx_take;
            // break held for the coded length
            // break begins 10.5 ETU after the start edge
            if (in_rx && brk_on_q && half_step && hpos_next == sc_char_pkg::BRK_START_HALF)
            begin
                io_out <= 1'b0;
                io_oe <= 1'b1;
            end
            else if (in_rx && half_step && hpos_next == brk_end)
            begin
                io_out <= 1'b1;
                io_oe <= 1'b0;
            end
            else if (tx_take)
            begin
                io_out <= 1'b0;
                io_oe <= 1'b1;
            end
            else if (in_tx && half_step && !hpos_next[0])
            begin
                io_oe <= hpos_next < sc_char_pkg::RX_END_HALF;
                io_out <= (hpos_next < sc_char_pkg::RX_END_HALF) ? tx_frame_q[1] : 1'b1;
            end
        end
    end
endmodule // sc_char_ctrl

// ==== testbench/sc_char_ctrl_chk.sv ====
/*
 * port checker for the smart card character controller.
 * assumes one hclk domain and the active low async reset hresetn.
 */
`timescale 1ns/1ps
module sc_char_ctrl_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic io_out,
    input wire logic io_oe,
    input wire logic card_clk,
    input wire logic tx_busy,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_parity_err
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // bus always answers at once and never errors
    a_bus_zero_wait: assert property (hreadyout && !hresp)
        else $error("bus answer stalled or not okay");
    a_rdata_byte: assert property (hrdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    // card clock: 13 hclk per level; a divider stuck from reset passes here and only misses c_clk
    a_clk_half: assert property ($changed(card_clk) |-> ##13 $changed(card_clk))
        else $error("card clock half period wrong");
    a_rx_pulse: assert property (rx_valid |=> !rx_valid)
        else $error("receive strobe longer than one cycle");
    a_rx_hold: assert property (!rx_valid |-> $stable(rx_data) && $stable(rx_parity_err))
        else $error("receive data moved without strobe");
    // break pulls the line low; tx_busy is also high through a receive break, so these two checks never engage
    a_brk_low: assert property ((io_oe && !tx_busy) |-> !io_out)
        else $error("break drives line high");
    a_brk_cause: assert property (($rose(io_oe) && !tx_busy) |-> rx_parity_err)
        else $error("break without parity fault");
    // parity sampled at 9.5 etu, break only from 10.5 etu
    a_brk_late: assert property (rx_valid |=> (!io_oe)[*8])
        else $error("break too soon after parity");

    c_rx_err: cover property (rx_valid && rx_parity_err);
    c_brk: cover property ($rose(io_oe));
    c_clk: cover property ($changed(card_clk));
endmodule // sc_char_ctrl_chk

bind sc_char_ctrl sc_char_ctrl_chk sc_char_ctrl_chk_inst (
    .hclk(hclk),
    .hresetn(hresetn),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .io_out(io_out),
    .io_oe(io_oe),
    .card_clk(card_clk),
    .tx_busy(tx_busy),
    .rx_data(rx_data),
    .rx_valid(rx_valid),
    .rx_parity_err(rx_parity_err)
);

// ==== testbench/card_model.sv ====
/*
 * smart card on the io line: sends frames on request and times any
 * break the reader drives. assumes an open drain line with pull-up.
 */
`timescale 1ns/1ps
module card_model (
    input wire logic hclk,
    input wire logic io_line,
    output logic card_drv
);
    int cyc = 0;
    int t0 = 0;
    int lo_cnt = 0;
    int brk_len = 0;
    int brk_at = 0;

    initial card_drv = 1'b1;

    // time low spells that the card did not cause itself
    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (card_drv && !io_line)
        begin
            if (lo_cnt == 0)
                brk_at <= cyc - t0;
            lo_cnt <= lo_cnt + 1;
        end
        else if (lo_cnt != 0)
        begin
            brk_len <= lo_cnt;
            lo_cnt <= 0;
        end
    end

    // start bit, eight line levels lsb first, parity level, then release
    task automatic send(input logic [7:0] raw, input logic par, input int etu);
        logic [9:0] frame;
        frame = {par, raw, 1'b0};
        brk_len = 0;
        t0 = cyc;
        for (int k = 0; k < 10; k++)
        begin
            card_drv <= frame[k];
            repeat (etu) @(posedge hclk);
        end
        card_drv <= 1'b1;
    endtask

    // card break from 10.5 to 12 ETU after the reader's start bit
    task automatic nack(input int etu);
        repeat (21 * etu / 2) @(posedge hclk);
        card_drv <= 1'b0;
        repeat (3 * etu / 2) @(posedge hclk);
        card_drv <= 1'b1;
    endtask
endmodule // card_model

// ==== testbench/tb.sv ====
/*
 * testbench for sc_char_ctrl: AHB-Lite register access and card frames.
 * assumes the card model on an open drain line with pull-up.
 */
`timescale 1ns/1ps
module tb;
    localparam logic [15:0] CONV = sc_char_pkg::CONV_CTRL_IDX;
    localparam logic [15:0] RATE = sc_char_pkg::ETU_RATE_IDX;
    localparam logic [15:0] PAR = sc_char_pkg::PARITY_CTRL_IDX;
    localparam logic [15:0] LINK = sc_char_pkg::LINK_CTRL_IDX;
    localparam logic [15:0] STAT = sc_char_pkg::LINK_STATUS_IDX;
    localparam int E = 416; // 32 ticks of 13 hclk at code 0x96
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic tx_valid = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic [31:0] hrdata;
    logic hreadyout, hresp, io_out, io_oe, card_clk, tx_busy, rx_valid, rx_parity_err;
    logic [7:0] rx_data;
    logic card_drv;
    logic io_line;
    logic [31:0] rd;
    int n_mismatch = 0;
    int checked = 0;
    int n_rx = 0;
    int hl[4] = '{2, 3, 4, 4};
    logic [7:0] pc[3] = '{8'h40, 8'h20, 8'h00};

    always #5 hclk = ~hclk;
    // wired-and of reader drive and card drive over the pull-up
    assign io_line = card_drv & (io_oe ? io_out : 1'b1);

    sc_char_ctrl sc_char_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .io_in(io_line), .io_out(io_out), .io_oe(io_oe), .card_clk(card_clk),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_busy(tx_busy), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_parity_err(rx_parity_err));
    card_model card_model_inst (.hclk(hclk), .io_line(io_line), .card_drv(card_drv));

    // count receive strobes for the fifo side
    always @(posedge hclk)
        if (rx_valid === 1'b1)
            n_rx <= n_rx + 1;

    // one single word transfer; the master waits for ready in both phases
    task automatic bus(input logic [15:0] idx, input logic wr, input logic [7:0] wd);
        hsel <= 1'b1;
        haddr <= {14'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // measured spans carry sync and tick phase slack
    task automatic near(input string nm, input int seen, input int exp, input int tol);
        check(nm, {31'h0, (seen > exp - tol) && (seen < exp + tol)}, 32'h1);
    endtask

    // frame plus room for the longest break before the next step
    task automatic chr(input logic [7:0] raw, input logic par, input int e);
        card_model_inst.send(raw, par, e);
        repeat (3 * e) @(posedge hclk);
    endtask

    task wrap_up;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // hang guard, about half again the expected run
    initial
    begin
        #950000;
        n_mismatch++;
        wrap_up();
    end

    // main sequence
    initial
    begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(RATE, 1'b0, 8'h00);
        check("rate_reset", rd, 32'h11);
        bus(CONV, 1'b0, 8'h00);
        check("conv_reset", rd, 32'h2C);
        bus(16'hFE30, 1'b0, 8'h00);
        check("unmapped", rd, 32'h0);
        bus(RATE, 1'b1, 8'h96);
        bus(CONV, 1'b1, 8'h40);
        chr(8'h03, 1'b1, E);
        check("rx_data", {24'h0, rx_data}, 32'h3F);
        check("rx_count", n_rx, 32'h1);
        bus(CONV, 1'b0, 8'h00);
        check("conv_inverse", rd, 32'h04);
        bus(CONV, 1'b1, 8'h50);
        chr(8'h3B, 1'b0, E);
        bus(CONV, 1'b0, 8'h00);
        check("conv_direct", rd, 32'h34);
        check("ts_parity", {31'h0, rx_parity_err}, 32'h1);
        near("brk_len", card_model_inst.brk_len, 2 * E, 20);
        near("brk_at", card_model_inst.brk_at, 21 * E / 2, 40);
        for (int c = 1; c < 4; c += 2)
        begin
            bus(CONV, 1'b1, 8'h20 | 8'(c << 3));
            chr(8'h55, 1'b1, E);
            near("brk_len", card_model_inst.brk_len, hl[c] * E / 2, 20);
            check("rx_data", {24'h0, rx_data}, 32'h55);
        end
        bus(CONV, 1'b1, 8'h20);
        chr(8'h03, 1'b0, E);
        bus(CONV, 1'b0, 8'h00);
        check("conv_kept", rd, 32'h24);
        check("rx_direct", {24'h0, rx_data}, 32'h03);
        bus(CONV, 1'b1, 8'h00);
        bus(CONV, 1'b0, 8'h00);
        check("conv_write", rd, 32'h04);
        bus(CONV, 1'b1, 8'h20);
        bus(CONV, 1'b0, 8'h00);
        check("conv_restore", rd, 32'h24);
        for (int i = 0; i < 3; i++)
        begin
            bus(PAR, 1'b1, pc[i]);
            bus(LINK, 1'b1, {7'h0, i == 2});
            chr(8'h55, 1'b1, E);
            check("no_break", card_model_inst.brk_len, 32'h0);
        end
        bus(LINK, 1'b1, 8'h00);
        bus(RATE, 1'b1, 8'h95);
        chr(8'h55, 1'b1, 2 * E);
        near("brk_slow", card_model_inst.brk_len, 2 * E, 30);
        near("brk_at_slow", card_model_inst.brk_at, 21 * E, 60);
        // send one byte; the card refuses it with a break seen at 11 ETU
        tx_data <= 8'hA5;
        tx_valid <= 1'b1;
        @(posedge hclk);
        tx_valid <= 1'b0;
        card_model_inst.nack(2 * E);
        bus(STAT, 1'b0, 8'h00);
        check("card_brk", rd, 32'h03);
        bus(STAT, 1'b1, 8'h03);
        bus(STAT, 1'b0, 8'h00);
        check("status_clear", rd, 32'h00);
        wrap_up();
    end
endmodule // tb
